// *** tir_defines.svh ***
// Register offsets, field positions and reset values of the timer/IR bank.
// Assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register.
`ifndef TIR_DEFINES_SVH
`define TIR_DEFINES_SVH
`define TIR_ADDR_W 6
`define TIR_OFS_SCALE 6'h00
`define TIR_OFS_PDN 6'h04
`define TIR_OFS_ODN 6'h08
`define TIR_OFS_PUN 6'h0C
`define TIR_OFS_WDM 6'h10
`define TIR_OFS_MASK 6'h14
`define TIR_OFS_T1 6'h18
`define TIR_OFS_T2 6'h1C
`define TIR_OFS_STAT 6'h20
`define TIR_OFS_CTL 6'h24
`define TIR_OFS_T3 6'h28
`define TIR_OFS_HIGH 6'h2C
`define TIR_OFS_LOW 6'h30
`define TIR_BIT_T3SE 7
`define TIR_POS_T3SS 4
`define TIR_BIT_MODEN 3
`define TIR_BIT_HF 2
`define TIR_BIT_LGP 1
`define TIR_BIT_PINSEL 0
`define TIR_BIT_WATCHDOG_ENABLE 7
`define TIR_BIT_EIS 6
`define TIR_BIT_CONVERSION_IRQ_ENABLE 5
`define TIR_BIT_COMPARATOR_IRQ_ENABLE 4
`define TIR_BIT_WATCHDOG_PRESCALE_ENABLE 3
`define TIR_POS_PSW 0
`define TIR_BIT_GIE 0
`define TIR_BIT_CLK4 1
`define TIR_BIT_T2HBE 2
`define TIR_FLG_LOW 7
`define TIR_FLG_HIGH 6
`define TIR_FLG_T3 5
`define TIR_FLG_T2 4
`define TIR_FLG_T1 3
`define TIR_FLG_EXT 2
`define TIR_FLG_PCHG 1
`define TIR_FLG_MAIN 0
`define TIR_RST_CTRL 8'h00
`define TIR_RST_PAD 8'hFF
`define TIR_RESP_OKAY 2'h0
`define TIR_RESP_SLVERR 2'h2
`endif

// *** tir_pkg.sv ***
// Types shared by the timer/IR register bank.
// Assumes nothing beyond the defines header.
package tir_pkg;
   typedef struct packed {
      logic [7:0] pulldownN;
      logic [7:0] openDrainN;
      logic [7:0] pullupN;
   } tir_pad_t;
   typedef enum logic [3:0] {
      MOD_IDLE = 4'b0001,
      MOD_LOW = 4'b0010,
      MOD_HIGH = 4'b0100,
      MOD_DONE = 4'b1000
   } tir_mod_state_t;
endpackage

// *** tir_regs.sv ***
// Timer, IR/PWM modulator, pad and interrupt-mask register bank.
// Assumes a synchronous AXI4-Lite master and pin inputs synchronous to mclk.
//
// How it works
// - Scale enable off gives timer three 1:1
// - Scale select divides by two to code+1
// - Modulator off: output high, plain counter
// - HF mode: timer three counts low segments
// - PWM: high and low timers shape output
// - IR mode fills low segments with carrier
// - Long pulse ignores high time, single pulse
// - Pin select routes modulator to port6 bit7
// - Port5 pull-down controls are active low
// - Port6 open-drain controls are active low
// - Port5 pull-up controls are active low
// - Watchdog enable bit turns watchdog on
// - Ext select makes port6 bit0 interrupt input
// - Ext path blocked when select off; pin readable
// - Conversion and comparator interrupt enables
// - Watchdog prescaler 1:1 or 1:2 to 1:256
// - Mask register gates each flag source; conversion and comparator bypass it
// - Global enable set and cleared by software
// - Timer one 8-bit, read/write, reset clears
// - Timer one counts per instruction tick
// - Timer two low byte 8-bit, reset clears
// - Overflows set sticky flags; software clears
// - Status read returns flags AND mask
// - High-byte enable makes timer two 16-bit
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tir_defines.svh"
module tir_regs
   import tir_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [`TIR_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`TIR_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic mainTimerOvf,
   input wire logic [7:0] port5In,
   input wire logic convDone,
   input wire logic cmpChange,
   input wire logic wdtTick,
   input wire logic p67GpioOut,
   input wire logic p67GpioOe,
   input wire logic p67In,
   input wire logic p60In,
   output logic p67Out,
   output logic p67Oe,
   output logic p60Read,
   output tir_pad_t padCtl,
   output logic watchdogEnable,
   output logic wdtScaledTick,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] scaleQ, wdmQ, maskQ, ctlQ, flagQ, highQ, lowQ;
   logic [7:0] t1Q, t2Q, t2hQ, t3Q, t3PreQ, wdPreQ, modCntQ;
   logic [7:0] p5Q, flagSet, wrByte;
   logic [`TIR_ADDR_W-1:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic awReadyQ, wReadyQ, bValidQ, arReadyQ, rValidQ, doWr, wrOk;
   logic instrPhQ, instrTick, t3Base, t3Tick, p60Q, carrierQ, modOutQ;
   logic t1Wr, t2Wr, t3Wr, stWr, rdOk;
   logic [31:0] rdMux;
   tir_mod_state_t modQ;

   // Divide by 2^(code+1) when enabled: fires when low code+1 bits all set
   function automatic logic scaleHit(input logic en, input logic [2:0] sel,
                                     input logic [7:0] cnt);
      logic [7:0] m;
      m = 8'hFF >> (3'h7 - sel);
      return !en || ((cnt & m) == m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write: address and data taken in any order, reply follows both
   assign doWr = !awReadyQ && !wReadyQ && !bValidQ;
   assign wrByte = wDataQ[7:0];
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         awReadyQ <= 1'b1;
         wReadyQ <= 1'b1;
         bValidQ <= 1'b0;
         bresp <= `TIR_RESP_OKAY;
         awAddrQ <= '0;
         wDataQ <= '0;
         wStrbQ <= '0;
      end else begin
         if (awvalid && awReadyQ) begin
            awReadyQ <= 1'b0;
            awAddrQ <= awaddr;
         end
         if (wvalid && wReadyQ) begin
            wReadyQ <= 1'b0;
            wDataQ <= wdata;
            wStrbQ <= wstrb;
         end
         if (doWr) begin
            bValidQ <= 1'b1;
            bresp <= wrOk ? `TIR_RESP_OKAY : `TIR_RESP_SLVERR;
         end else if (bValidQ && bready) begin
            bValidQ <= 1'b0;
            awReadyQ <= 1'b1;
            wReadyQ <= 1'b1;
         end
      end
   end
   assign awready = awReadyQ;
   assign wready = wReadyQ;
   assign bvalid = bValidQ;

   // Only byte lane 0 carries a register; other lanes are dropped
   always_comb begin
      wrOk = (awAddrQ[1:0] == 2'h0) && (awAddrQ <= `TIR_OFS_LOW);
   end
   assign t1Wr = doWr && wrOk && wStrbQ[0] && awAddrQ == `TIR_OFS_T1;
   assign t2Wr = doWr && wrOk && wStrbQ[0] && awAddrQ == `TIR_OFS_T2;
   assign t3Wr = doWr && wrOk && wStrbQ[0] && awAddrQ == `TIR_OFS_T3;
   assign stWr = doWr && wrOk && wStrbQ[0] && awAddrQ == `TIR_OFS_STAT;

   ////////////////////////////////////////////////////////////////////////////
   // Plain control registers: 8 bits, read back as written, except CTL, which keeps only bits 2:0
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         scaleQ <= `TIR_RST_CTRL;
         padCtl <= {3{`TIR_RST_PAD}};
         wdmQ <= `TIR_RST_CTRL;
         maskQ <= `TIR_RST_CTRL;
         ctlQ <= `TIR_RST_CTRL;
         highQ <= `TIR_RST_CTRL;
         lowQ <= `TIR_RST_CTRL;
      end else if (doWr && wrOk && wStrbQ[0]) begin
         if (awAddrQ == `TIR_OFS_SCALE) begin
            scaleQ <= wrByte;
         end else if (awAddrQ == `TIR_OFS_PDN) begin
            padCtl.pulldownN <= wrByte;
         end else if (awAddrQ == `TIR_OFS_ODN) begin
            padCtl.openDrainN <= wrByte;
         end else if (awAddrQ == `TIR_OFS_PUN) begin
            padCtl.pullupN <= wrByte;
         end else if (awAddrQ == `TIR_OFS_WDM) begin
            wdmQ <= wrByte;
         end else if (awAddrQ == `TIR_OFS_MASK) begin
            maskQ <= wrByte;
         end else if (awAddrQ == `TIR_OFS_CTL) begin
            ctlQ <= {5'h00, wrByte[2:0]};
         end else if (awAddrQ == `TIR_OFS_HIGH) begin
            highQ <= wrByte;
         end else if (awAddrQ == `TIR_OFS_LOW) begin
            lowQ <= wrByte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read: one cycle from address taken to data valid
   always_comb begin
      rdOk = (araddr[1:0] == 2'h0) && (araddr <= `TIR_OFS_LOW);
      rdMux = 32'h0000_0000;
      if (araddr == `TIR_OFS_SCALE) begin
         rdMux[7:0] = scaleQ;
      end else if (araddr == `TIR_OFS_PDN) begin
         rdMux[7:0] = padCtl.pulldownN;
      end else if (araddr == `TIR_OFS_ODN) begin
         rdMux[7:0] = padCtl.openDrainN;
      end else if (araddr == `TIR_OFS_PUN) begin
         rdMux[7:0] = padCtl.pullupN;
      end else if (araddr == `TIR_OFS_WDM) begin
         rdMux[7:0] = wdmQ;
      end else if (araddr == `TIR_OFS_MASK) begin
         rdMux[7:0] = maskQ;
      end else if (araddr == `TIR_OFS_T1) begin
         rdMux[7:0] = t1Q;
      end else if (araddr == `TIR_OFS_T2) begin
         rdMux[7:0] = t2Q;
      end else if (araddr == `TIR_OFS_STAT) begin
         rdMux[7:0] = flagQ & maskQ;
      end else if (araddr == `TIR_OFS_CTL) begin
         rdMux[7:0] = ctlQ;
      end else if (araddr == `TIR_OFS_T3) begin
         rdMux[7:0] = t3Q;
      end else if (araddr == `TIR_OFS_HIGH) begin
         rdMux[7:0] = highQ;
      end else if (araddr == `TIR_OFS_LOW) begin
         rdMux[7:0] = lowQ;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         arReadyQ <= 1'b1;
         rValidQ <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `TIR_RESP_OKAY;
      end else if (arvalid && arReadyQ) begin
         arReadyQ <= 1'b0;
         rValidQ <= 1'b1;
         rdata <= rdMux;
         rresp <= rdOk ? `TIR_RESP_OKAY : `TIR_RESP_SLVERR;
      end else if (rValidQ && rready) begin
         rValidQ <= 1'b0;
         arReadyQ <= 1'b1;
      end
   end
   assign arready = arReadyQ;
   assign rvalid = rValidQ;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction tick: every mclk in two-clock option, every other in four
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         instrPhQ <= 1'b0;
      end else begin
         instrPhQ <= !instrPhQ;
      end
   end
   assign instrTick = !ctlQ[`TIR_BIT_CLK4] || instrPhQ;

   // Timer one and two: writes win over counting
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         t1Q <= 8'h00;
         t2Q <= 8'h00;
         t2hQ <= 8'h00;
      end else begin
         if (t1Wr) begin
            t1Q <= wrByte;
         end else if (instrTick) begin
            t1Q <= t1Q + 8'h01;
         end
         if (t2Wr) begin
            t2Q <= wrByte;
         end else if (instrTick) begin
            t2Q <= t2Q + 8'h01;
         end
         if (!ctlQ[`TIR_BIT_T2HBE]) begin
            t2hQ <= 8'h00;
         end else if (instrTick && t2Q == 8'hFF) begin
            t2hQ <= t2hQ + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer three: in IR mode it only runs inside low segments
   assign t3Base = instrTick && (!(scaleQ[`TIR_BIT_MODEN] &&
      scaleQ[`TIR_BIT_HF]) || modQ == MOD_LOW);
   assign t3Tick = t3Base && scaleHit(scaleQ[`TIR_BIT_T3SE],
      scaleQ[`TIR_POS_T3SS+:3], t3PreQ);
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         t3PreQ <= 8'h00;
         t3Q <= 8'h00;
         carrierQ <= 1'b0;
      end else begin
         if (t3Base) begin
            t3PreQ <= t3PreQ + 8'h01;
         end
         if (t3Wr) begin
            t3Q <= wrByte;
         end else if (t3Tick) begin
            t3Q <= t3Q + 8'h01;
         end
         // Carrier half period is one timer-three wrap
         if (modQ != MOD_LOW) begin
            carrierQ <= 1'b0;
         end else if (t3Tick && t3Q == 8'hFF) begin
            carrierQ <= !carrierQ;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modulator: low segment then high segment, one tick per count
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         modQ <= MOD_IDLE;
         modCntQ <= 8'h00;
      end else if (!scaleQ[`TIR_BIT_MODEN]) begin
         modQ <= MOD_IDLE;
      end else begin
         case (modQ)
            MOD_IDLE: begin
               modQ <= MOD_LOW;
               modCntQ <= lowQ;
            end
            MOD_LOW: begin
               if (instrTick && modCntQ == 8'h00) begin
                  modQ <= scaleQ[`TIR_BIT_LGP] ? MOD_DONE : MOD_HIGH;
                  modCntQ <= highQ;
               end else if (instrTick) begin
                  modCntQ <= modCntQ - 8'h01;
               end
            end
            MOD_HIGH: begin
               if (instrTick && modCntQ == 8'h00) begin
                  modQ <= MOD_LOW;
                  modCntQ <= lowQ;
               end else if (instrTick) begin
                  modCntQ <= modCntQ - 8'h01;
               end
            end
            default: begin
               modQ <= MOD_DONE;
            end
         endcase
      end
   end

   // IR mode fills low with carrier; PWM mode drives it solid low
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         modOutQ <= 1'b1;
      end else if (modQ == MOD_LOW) begin
         modOutQ <= scaleQ[`TIR_BIT_HF] ? carrierQ : 1'b0;
      end else begin
         modOutQ <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins; port6 bit7 is forced to output by the pin select, else follows p67GpioOe
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         p67Out <= 1'b0;
         p67Oe <= 1'b0;
         p60Read <= 1'b0;
         p60Q <= 1'b1;
         // Seeded from the pins so that leaving reset shows no false change
         p5Q <= port5In;
      end else begin
         p67Out <= scaleQ[`TIR_BIT_PINSEL] ? modOutQ : p67GpioOut;
         p67Oe <= scaleQ[`TIR_BIT_PINSEL] || p67GpioOe;
         p60Read <= p60In;
         p60Q <= p60In;
         p5Q <= port5In;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags: hardware set wins over a software clear in one cycle
   always_comb begin
      flagSet = 8'h00;
      flagSet[`TIR_FLG_LOW] = modQ == MOD_LOW && instrTick && modCntQ == 8'h00;
      flagSet[`TIR_FLG_HIGH] = modQ == MOD_HIGH && instrTick &&
         modCntQ == 8'h00;
      flagSet[`TIR_FLG_T3] = t3Tick && !t3Wr && t3Q == 8'hFF;
      flagSet[`TIR_FLG_T2] = instrTick && !t2Wr && t2Q == 8'hFF &&
         (!ctlQ[`TIR_BIT_T2HBE] || t2hQ == 8'hFF);
      flagSet[`TIR_FLG_T1] = instrTick && !t1Wr && t1Q == 8'hFF;
      flagSet[`TIR_FLG_EXT] = wdmQ[`TIR_BIT_EIS] && p60Q && !p60In;
      flagSet[`TIR_FLG_PCHG] = p5Q != port5In;
      flagSet[`TIR_FLG_MAIN] = mainTimerOvf;
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         flagQ <= 8'h00;
      end else if (stWr) begin
         flagQ <= (flagQ & wrByte) | flagSet;
      end else begin
         flagQ <= flagQ | flagSet;
      end
   end

   // Request: masked flags or enabled side sources, under global enable
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= ctlQ[`TIR_BIT_GIE] && (|(flagQ & maskQ) ||
            (convDone && wdmQ[`TIR_BIT_CONVERSION_IRQ_ENABLE]) ||
            (cmpChange && wdmQ[`TIR_BIT_COMPARATOR_IRQ_ENABLE]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog enable and prescaled tick towards the watchdog counter
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wdPreQ <= 8'h00;
         wdtScaledTick <= 1'b0;
         watchdogEnable <= 1'b0;
      end else begin
         watchdogEnable <= wdmQ[`TIR_BIT_WATCHDOG_ENABLE];
         wdtScaledTick <= wdtTick && wdmQ[`TIR_BIT_WATCHDOG_ENABLE] &&
            scaleHit(wdmQ[`TIR_BIT_WATCHDOG_PRESCALE_ENABLE], wdmQ[`TIR_POS_PSW+:3], wdPreQ);
         if (wdtTick) begin
            wdPreQ <= wdPreQ + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_mod_off;
      !scaleQ[`TIR_BIT_MODEN] |=> ##1 modOutQ;
   endproperty
   a_mod_off: assert property (p_mod_off)
      else $error("modulator off but output not high");
   property p_pin_sel;
      scaleQ[`TIR_BIT_PINSEL] |=> p67Oe && p67Out == $past(modOutQ);
   endproperty
   a_pin_sel: assert property (p_pin_sel)
      else $error("pin select not routing modulator");
   property p_ext_block;
      !wdmQ[`TIR_BIT_EIS] && !flagQ[`TIR_FLG_EXT] |=> !flagQ[`TIR_FLG_EXT];
   endproperty
   a_ext_block: assert property (p_ext_block)
      else $error("external flag set while path blocked");
   property p_t1_wrap;
      t1Q == 8'hFF && instrTick && !t1Wr |=> t1Q == 8'h00 &&
         flagQ[`TIR_FLG_T1];
   endproperty
   a_t1_wrap: assert property (p_t1_wrap)
      else $error("timer one overflow wrong");
   property p_stat_read;
      arvalid && arReadyQ && araddr == `TIR_OFS_STAT |=>
         rdata[7:0] == ($past(flagQ) & $past(maskQ));
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status read not masked");
   property p_gie_off;
      !ctlQ[`TIR_BIT_GIE] |=> !irq;
   endproperty
   a_gie_off: assert property (p_gie_off)
      else $error("request without global enable");
   property p_flag_hold;
      flagQ[`TIR_FLG_MAIN] && !stWr |=> flagQ[`TIR_FLG_MAIN];
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag lost without clear");
   property p_t3_scale_off;
      !scaleQ[`TIR_BIT_T3SE] |-> t3Tick == t3Base;
   endproperty
   a_t3_scale_off: assert property (p_t3_scale_off)
      else $error("timer three not 1:1");
   property p_t2_8bit;
      !ctlQ[`TIR_BIT_T2HBE] && t2Q == 8'hFF && instrTick && !t2Wr |=>
         t2Q == 8'h00 && flagQ[`TIR_FLG_T2];
   endproperty
   a_t2_8bit: assert property (p_t2_8bit)
      else $error("timer two 8-bit overflow wrong");
   property p_irq_req;
      ctlQ[`TIR_BIT_GIE] && (flagQ[`TIR_FLG_T1] && maskQ[`TIR_FLG_T1]) |=> irq;
   endproperty
   a_irq_req: assert property (p_irq_req)
      else $error("masked flag did not raise request");
   property p_wr_done;
      bValidQ && !bready |=> bValidQ;
   endproperty
   c_wr_done: cover property (p_wr_done);
   property p_low_seg;
      modQ == MOD_LOW ##1 modQ == MOD_HIGH;
   endproperty
   c_low_seg: cover property (p_low_seg);
   property p_irq_rise;
      !irq ##1 irq;
   endproperty
   c_irq_rise: cover property (p_irq_rise);
endmodule // tir_regs
`default_nettype wire

// *** tir_tb.sv ***
// Self-checking bench for the timer/IR register bank.
// Assumes tir_regs, tir_pkg and tir_defines.svh; drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`include "tir_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
 $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
   import tir_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic mainTimerOvf = 1'b0, convDone = 1'b0, cmpChange = 1'b0;
   logic wdtTick = 1'b0, p67GpioOut = 1'b0, p67GpioOe = 1'b1;
   logic p67In = 1'b0, p60In = 1'b1;
   logic [7:0] port5In = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, p67Out, p67Oe, p60Read;
   logic watchdogEnable, wdtScaledTick, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   tir_pad_t padCtl;
   int fail_count = 0;
   int check_count = 0;
   localparam logic [1:0] OK = `TIR_RESP_OKAY;
   localparam logic [1:0] ERR = `TIR_RESP_SLVERR;
   always #25 mclk = ~mclk;
   tir_regs i_tir_regs (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .mainTimerOvf(mainTimerOvf), .port5In(port5In),
      .convDone(convDone), .cmpChange(cmpChange), .wdtTick(wdtTick),
      .p67GpioOut(p67GpioOut), .p67GpioOe(p67GpioOe), .p67In(p67In),
      .p60In(p60In), .p67Out(p67Out), .p67Oe(p67Oe), .p60Read(p60Read),
      .padCtl(padCtl), .watchdogEnable(watchdogEnable),
      .wdtScaledTick(wdtScaledTick), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Trailing edge keeps the next call from re-driving in the same step
   task automatic wr(input logic [5:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int n;
      bit done;
      n = 0;
      done = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && n < 200) begin
         @(posedge mclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            `CHK(bresp, er)
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) `CHK(1'b0, 1'b1)
      @(posedge mclk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
      int n;
      bit done;
      n = 0;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && n < 200) begin
         @(posedge mclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            `CHK(rdata, {24'h0, ed})
            `CHK(rresp, er)
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) `CHK(1'b0, 1'b1)
      @(posedge mclk);
   endtask
   task automatic lows(output int c);
      c = 0;
      repeat (32) begin
         @(posedge mclk);
         c += (p67Out === 1'b0);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   logic [5:0] ofs [6] = '{`TIR_OFS_SCALE, `TIR_OFS_PDN, `TIR_OFS_ODN,
                           `TIR_OFS_PUN, `TIR_OFS_WDM, `TIR_OFS_MASK};
   logic [7:0] rv [6] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
   initial begin
      int c;
      cyc(5);
      rst_b <= 1'b1;
      cyc(1);
      for (int i = 0; i < 6; i++) rd(ofs[i], rv[i], OK);
      rd(`TIR_OFS_CTL, 8'h00, OK);
      for (int i = 0; i < 6; i++) wr(ofs[i], 8'h5A, OK);
      for (int i = 0; i < 6; i++) rd(ofs[i], 8'h5A, OK);
      `CHK(padCtl, 24'h5A5A5A)
      `CHK(watchdogEnable, 1'b0)
      for (int i = 0; i < 6; i++) wr(ofs[i], 8'hA5, OK);
      for (int i = 0; i < 6; i++) rd(ofs[i], 8'hA5, OK);
      `CHK(padCtl, 24'hA5A5A5)
      `CHK(watchdogEnable, 1'b1)
      wr(6'h34, 8'h11, ERR);
      wr(6'h05, 8'h11, ERR);
      rd(6'h34, 8'h00, ERR);
      wstrb <= 4'hE;
      wr(`TIR_OFS_MASK, 8'h77, OK);
      wstrb <= 4'hF;
      rd(`TIR_OFS_MASK, 8'hA5, OK);
      $display("test registers done");
      // Modulator off: pin follows GPIO unless selected; then PWM and long pulse low counts
      wr(`TIR_OFS_SCALE, 8'h00, OK);
      cyc(2);
      `CHK({p67Out, p67Oe}, 2'h1)
      wr(`TIR_OFS_SCALE, 8'h01, OK);
      cyc(2);
      `CHK({p67Out, p67Oe}, 2'h3)
      wr(`TIR_OFS_HIGH, 8'h03, OK);
      wr(`TIR_OFS_LOW, 8'h03, OK);
      wr(`TIR_OFS_SCALE, 8'h09, OK);
      cyc(20);
      lows(c);
      `CHK(c, 16)
      wr(`TIR_OFS_SCALE, 8'h01, OK);
      wr(`TIR_OFS_SCALE, 8'h0B, OK);
      cyc(20);
      lows(c);
      `CHK(c, 0)
      wr(`TIR_OFS_SCALE, 8'h00, OK);
      $display("test modulator done");
      // Flags, masks and global enable
      wr(`TIR_OFS_WDM, 8'h00, OK);
      wr(`TIR_OFS_MASK, 8'h05, OK);
      wr(`TIR_OFS_STAT, 8'h00, OK);
      p60In <= 1'b0;
      cyc(3);
      rd(`TIR_OFS_STAT, 8'h00, OK);
      p60In <= 1'b1;
      wr(`TIR_OFS_WDM, 8'h40, OK);
      p60In <= 1'b0;
      cyc(3);
      `CHK(p60Read, 1'b0)
      rd(`TIR_OFS_STAT, 8'h04, OK);
      mainTimerOvf <= 1'b1;
      cyc(1);
      mainTimerOvf <= 1'b0;
      cyc(2);
      rd(`TIR_OFS_STAT, 8'h05, OK);
      `CHK(irq, 1'b0)
      wr(`TIR_OFS_CTL, 8'h01, OK);
      cyc(2);
      `CHK(irq, 1'b1)
      wr(`TIR_OFS_STAT, 8'hFE, OK);
      rd(`TIR_OFS_STAT, 8'h04, OK);
      wr(`TIR_OFS_MASK, 8'h00, OK);
      cyc(2);
      `CHK(irq, 1'b0)
      rd(`TIR_OFS_STAT, 8'h00, OK);
      wr(`TIR_OFS_MASK, 8'h04, OK);
      rd(`TIR_OFS_STAT, 8'h04, OK);
      wr(`TIR_OFS_MASK, 8'h00, OK);
      wr(`TIR_OFS_WDM, 8'h20, OK);
      convDone <= 1'b1;
      cyc(3);
      `CHK(irq, 1'b1)
      wr(`TIR_OFS_WDM, 8'h10, OK);
      cyc(2);
      `CHK(irq, 1'b0)
      cmpChange <= 1'b1;
      cyc(3);
      `CHK(irq, 1'b1)
      wr(`TIR_OFS_CTL, 8'h00, OK);
      cyc(2);
      `CHK(irq, 1'b0)
      convDone <= 1'b0;
      cmpChange <= 1'b0;
      $display("test interrupts done");
      // Timers count from loaded values; four-clock or 1:2 halves the rate
      wr(`TIR_OFS_MASK, 8'h38, OK);
      for (int k = 0; k < 2; k++) begin
         wr(`TIR_OFS_CTL, k ? 8'h02 : 8'h00, OK);
         wr(`TIR_OFS_SCALE, k ? 8'h00 : 8'h80, OK);
         wr(`TIR_OFS_T1, 8'h80, OK);
         wr(`TIR_OFS_T2, 8'h80, OK);
         wr(`TIR_OFS_T3, 8'h80, OK);
         wr(`TIR_OFS_STAT, 8'h00, OK);
         rd(`TIR_OFS_STAT, 8'h00, OK);
         cyc(140);
         rd(`TIR_OFS_STAT, k ? 8'h00 : 8'h18, OK);
         cyc(140);
         rd(`TIR_OFS_STAT, 8'h38, OK);
      end
      $display("test timer done");
      // Watchdog scaler over 256 ticks, every code and 1:1
      for (int j = 0; j < 9; j++) begin
         // Scaled ticks only pass while the watchdog itself is on
         wr(`TIR_OFS_WDM, j == 8 ? 8'h80 : 8'h88 | j[7:0], OK);
         c = 0;
         for (int k = 0; k < 516; k++) begin
            wdtTick <= (k < 512) && (k % 2 == 0);
            @(posedge mclk);
            c += (wdtScaledTick === 1'b1);
         end
         `CHK(c, j == 8 ? 256 : 256 >> (j + 1))
      end
      $display("test watchdog done");
      // Mid-run reset: counters restart from zero, pad controls return to FF, enables clear
      rst_b <= 1'b0;
      cyc(2);
      rst_b <= 1'b1;
      cyc(1);
      rd(`TIR_OFS_T1, 8'h01, OK);
      rd(`TIR_OFS_T2, 8'h04, OK);
      `CHK({padCtl, watchdogEnable}, 25'h1FFFFFE)
      $display("test reset done");
      summarize();
   end
   initial begin
      cyc(20000);
      fail_count++;
      summarize();
   end
endmodule // testbench
`default_nettype wire
